// ### spi_regs_pkg.sv
/*
 * constants for the serial peripheral controller: register offsets, field
 * positions, status bit positions, reset values and timing units.
 * assumes a 32-bit apb register bus with byte addresses on paddr.
 */
// Summary of operation
// [R1] receive code field shows select lines at transfer end in master, else zero
// [R2] software writes each transmit word right-aligned in bits 15..0
// [R3] per-word select code is used only when variable select mode is 1
// [R4] decoding off: select lines follow priority of the code; 1111 selects none
// [R5] decoding on: select lines equal the four-bit code directly
// [R6] in variable select mode, final-transfer flag releases the select line after the word, even if held
// [R7] receive-full sets on receive load, clears on receive holding read
// [R8] transmit-empty clears on write, sets on move; zero while disabled
// [R9] mode-fault sets on a detected fault, clears on status read
// [R10] overrun sets on a second load without read, clears on status read
// [R11] receive-count-done sets when receive counter reaches zero, cleared by write
// [R12] transmit-count-done sets when transmit counter reaches zero, cleared by write
// [R13] buffers-exhausted flags are high exactly when both counters are zero
// [R14] slave-select-rise sets on rising slave select, clears on status read
// [R15] transmitter-idle clears on write, sets when all empty and delay done
// [R16] enable-state bit 16 reads one while enabled
// [R17] writing one to interrupt-enable sets that mask bit
// [R18] writing one to interrupt-disable clears that mask bit
// [R19] interrupt-mask view returns the mask in status layout
// [R20] variable select takes code per word; fixed takes mode register code
// [R21] hold-select keeps the line active until another select is requested
// [R22] status register resets to 0x000000f0
// [R23] interrupt output is high when any flag is set with its mask bit
package spi_regs_pkg;
   // register byte offsets
   localparam logic [7:0] OFF_CTRL = 8'h00;
   localparam logic [7:0] OFF_MODE = 8'h04;
   localparam logic [7:0] OFF_RX_HOLDING = 8'h08;
   localparam logic [7:0] OFF_TX_HOLDING = 8'h0c;
   localparam logic [7:0] OFF_STATUS_FLAGS = 8'h10;
   localparam logic [7:0] OFF_IRQ_ENABLE_SET = 8'h14;
   localparam logic [7:0] OFF_IRQ_ENABLE_CLEAR = 8'h18;
   localparam logic [7:0] OFF_IRQ_ENABLE_VIEW = 8'h1c;
   localparam logic [3:0] CSR_PAGE = 4'h3; // 0x30..0x3c, index in addr[3:2]
   // control fields
   localparam int CTRL_ENABLE = 0;
   localparam int CTRL_DISABLE = 1;
   localparam int CTRL_SOFT_RESET = 7;
   localparam int CTRL_FINAL = 24;
   // mode fields
   localparam int MODE_MASTER = 0;
   localparam int MODE_VAR_SELECT = 1;
   localparam int MODE_DECODE = 2;
   localparam int MODE_NO_FAULT = 4;
   localparam int MODE_LOOPBACK = 7;
   localparam int MODE_CODE_LSB = 16;
   // transmit holding fields
   localparam int TX_WORD_W = 16;
   localparam int TX_CODE_LSB = 16;
   localparam int TX_FINAL = 24;
   // chip select register fields
   localparam int CSR_HOLD = 3;
   localparam int CSR_BITS_LSB = 4;
   localparam int CSR_SCBR_LSB = 8;
   localparam int CSR_DLYBCT_LSB = 24;
   // status bit positions
   localparam int ST_RX_FULL = 0;
   localparam int ST_TX_EMPTY = 1;
   localparam int ST_FAULT = 2;
   localparam int ST_OVERRUN = 3;
   localparam int ST_RX_DONE = 4;
   localparam int ST_TX_DONE = 5;
   localparam int ST_RX_EXH = 6;
   localparam int ST_TX_EXH = 7;
   localparam int ST_SS_RISE = 8;
   localparam int ST_IDLE_FLAG = 9;
   localparam int ST_ENABLE = 16;
   localparam int IRQ_SRC_W = 10;
   localparam logic [31:0] STATUS_RESET = 32'h000000f0;
   localparam logic [3:0] CS_NONE = 4'hf;
   localparam logic [4:0] MIN_BITS = 5'h08;
   localparam logic [4:0] MAX_BITS = 5'h10;
   localparam int GAP_UNIT = 32; // inter-transfer delay unit, ref_clk cycles
   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_SHIFT = 2'b01,
      ST_GAP = 2'b10
   } xfer_state_t;
endpackage : spi_regs_pkg

// ### spi_status_irq_regs.sv
/*
 * serial peripheral controller core: apb register file, status and
 * interrupt mask logic, chip select generation and a small master shifter.
 * assumes apb master on ref_clk, dma counters from logic on ref_clk, and
 * miso / slave select arriving asynchronously from pins.
 */
// Chosen here: the placing of the registers and the APB slave port.
`timescale 1ns/1ps
module spi_status_irq_regs #(
   parameter int CNT_W = 16
) (
   input wire logic ref_clk,
   input wire logic reset,
   input wire logic [7:0] paddr,
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   output logic spck,
   output logic mosi,
   input wire logic miso,
   input wire logic slave_select_input,
   output logic [3:0] chip_select_lines,
   input wire logic [CNT_W-1:0] receive_counter,
   input wire logic [CNT_W-1:0] receive_next_counter,
   input wire logic [CNT_W-1:0] transmit_counter,
   input wire logic [CNT_W-1:0] transmit_next_counter,
   input wire logic receive_counter_write,
   input wire logic transmit_counter_write,
   output logic irq
);
   import spi_regs_pkg::*;

   // priority encoding of a select code onto the active-low lines
   function automatic logic [3:0] prio_lines(input logic [3:0] code);
      logic [3:0] r;
      r = CS_NONE;
      if (!code[0]) r = 4'he;
      else if (!code[1]) r = 4'hd;
      else if (!code[2]) r = 4'hb;
      else if (!code[3]) r = 4'h7;
      return r;
   endfunction : prio_lines

   // which chip select register governs a code
   function automatic logic [1:0] csr_index(input logic [3:0] code,
                                             input logic dec);
      logic [1:0] r;
      r = 2'h3;
      if (dec) r = code[3:2];
      else if (!code[0]) r = 2'h0;
      else if (!code[1]) r = 2'h1;
      else if (!code[2]) r = 2'h2;
      return r;
   endfunction : csr_index

   xfer_state_t state;
   logic [31:0] mode_reg;
   logic [31:0] csr [0:3];
   logic [31:0] tx_hold;
   logic tx_full;
   logic [15:0] rx_data;
   logic [3:0] rx_code;
   logic enabled;
   logic dis_pending;
   logic rx_full, tx_empty, fault, overrun, rx_done, tx_done;
   logic ss_rise, idle_flag;
   logic [IRQ_SRC_W-1:0] mask;
   logic miso_m, miso_s, ss_m, ss_s, ss_d;
   logic rx_zero_d, tx_zero_d;
   logic [15:0] tx_sh, rx_sh;
   logic [4:0] nbits, bit_cnt;
   logic [7:0] div_cnt, half_div;
   logic [12:0] gap_cnt;
   logic [3:0] cur_code;
   logic [1:0] cur_idx;
   logic cs_active, sh_final;

   // apb decode; the slave never inserts wait states
   wire setup = psel & ~penable;
   wire access = psel & penable;
   wire wr = access & pwrite;
   wire rd = access & ~pwrite;
   wire hit_ctrl = paddr == OFF_CTRL;
   wire hit_mode = paddr == OFF_MODE;
   wire hit_rx = paddr == OFF_RX_HOLDING;
   wire hit_tx = paddr == OFF_TX_HOLDING;
   wire hit_stat = paddr == OFF_STATUS_FLAGS;
   wire hit_ies = paddr == OFF_IRQ_ENABLE_SET;
   wire hit_iec = paddr == OFF_IRQ_ENABLE_CLEAR;
   wire hit_iev = paddr == OFF_IRQ_ENABLE_VIEW;
   wire hit_csr = (paddr[7:4] == CSR_PAGE) & (paddr[1:0] == 2'h0);
   wire mapped = hit_ctrl | hit_mode | hit_rx | hit_tx | hit_stat |
                 hit_ies | hit_iec | hit_iev | hit_csr;
   wire wr_ctrl = wr & hit_ctrl;
   wire wr_tx = wr & hit_tx;
   wire rd_rx = rd & hit_rx;
   wire rd_stat = rd & hit_stat;
   wire soft_reset = wr_ctrl & pwdata[CTRL_SOFT_RESET];
   wire rst_all = reset | soft_reset; // dma counters live outside, untouched
   wire cmd_dis = wr_ctrl & pwdata[CTRL_DISABLE];
   wire cmd_en = wr_ctrl & pwdata[CTRL_ENABLE] & ~pwdata[CTRL_DISABLE];
   assign pready = 1'b1;
   assign pslverr = access & ~mapped;

   // mode decode
   wire master = mode_reg[MODE_MASTER];
   wire dec = mode_reg[MODE_DECODE];
   wire [3:0] word_code = mode_reg[MODE_VAR_SELECT] ? // [R3] [R20]
                          tx_hold[TX_CODE_LSB+:4] :
                          mode_reg[MODE_CODE_LSB+:4];
   wire [1:0] word_idx = csr_index(word_code, dec);
   wire [31:0] word_csr = csr[word_idx];
   wire [4:0] word_bits_raw = MIN_BITS + {1'b0, word_csr[CSR_BITS_LSB+:4]};
   wire [4:0] word_bits = (word_bits_raw > MAX_BITS) ? MAX_BITS :
                          word_bits_raw; // reserved widths clamp to 16
   wire cur_hold = csr[cur_idx][CSR_HOLD];
   wire [7:0] word_scbr = word_csr[CSR_SCBR_LSB+:8];
   wire [7:0] cur_dlybct = csr[cur_idx][CSR_DLYBCT_LSB+:8];

   // select lines: direct code with decoding on, priority code otherwise
   wire [3:0] drive_lines = dec ? cur_code : prio_lines(cur_code); // [R4] [R5]
   assign chip_select_lines = cs_active ? drive_lines : CS_NONE;

   // status word and counters; exhaustion flags are live comparisons
   wire rx_zero = receive_counter == '0;
   wire tx_zero = transmit_counter == '0;
   wire rx_bufs_ex = rx_zero & (receive_next_counter == '0); // [R13]
   wire tx_bufs_ex = tx_zero & (transmit_next_counter == '0); // [R13]
   wire [IRQ_SRC_W-1:0] flags = {idle_flag, ss_rise, tx_bufs_ex, rx_bufs_ex,
                                 tx_done, rx_done, overrun, fault,
                                 tx_empty, rx_full};
   wire [31:0] status_word = {15'h0, enabled, 6'h0, flags}; // [R16]
   assign irq = |(flags & mask); // [R23]

   // transfer control
   wire start = enabled & master & tx_full & (state == ST_IDLE);
   wire [7:0] half_now = (word_scbr == 8'h00) ? 8'h01 : word_scbr; // next word
   wire div_tick = (state == ST_SHIFT) & (div_cnt == half_div - 8'h01);
   wire last_bit = div_tick & spck & (bit_cnt == nbits - 5'h01);
   wire rx_load = last_bit;
   wire gap_end = (state == ST_GAP) & (gap_cnt == 13'h0000);
   wire release_cs = gap_end & (sh_final | ~cur_hold); // [R6] [R21]
   wire miso_bit = mode_reg[MODE_LOOPBACK] ? mosi : miso_s;
   wire fault_cond = enabled & master & ~mode_reg[MODE_NO_FAULT] & ~ss_s;
   wire ss_edge = ss_s & ~ss_d;
   wire en_drop = fault_cond | ((cmd_dis | dis_pending) & (state == ST_IDLE));

   // read mux; reserved and write-only locations read zero
   wire [3:0] rx_code_view = master ? rx_code : 4'h0; // [R1]
   wire [31:0] rd_mux =
      hit_mode ? mode_reg :
      hit_rx ? {12'h000, rx_code_view, rx_data} :
      hit_stat ? status_word :
      hit_iev ? {{(32-IRQ_SRC_W){1'b0}}, mask} : // [R19]
      hit_csr ? csr[paddr[3:2]] : 32'h0000_0000;

   // read data is captured in the setup cycle so it is steady in access
   always_ff @(posedge ref_clk) begin
      if (reset) prdata <= 32'h0000_0000;
      else if (setup) prdata <= rd_mux;
   end

   // pin synchronisers; only the second stages and the ss_d delay feed logic
   always_ff @(posedge ref_clk) begin
      if (reset) begin
         miso_m <= 1'b0;
         miso_s <= 1'b0;
         ss_m <= 1'b1;
         ss_s <= 1'b1;
         ss_d <= 1'b1;
      end else begin
         miso_m <= miso;
         miso_s <= miso_m;
         ss_m <= slave_select_input;
         ss_s <= ss_m;
         ss_d <= ss_s;
      end
   end

   // configuration registers
   always_ff @(posedge ref_clk) begin
      if (rst_all) begin
         mode_reg <= 32'h0000_0000;
         for (int i = 0; i < 4; i++) csr[i] <= 32'h0000_0000;
      end else if (wr & hit_mode) begin
         mode_reg <= pwdata;
      end else if (wr & hit_csr) begin
         csr[paddr[3:2]] <= pwdata;
      end
   end

   // interrupt mask: set-only and clear-only write ports
   always_ff @(posedge ref_clk) begin
      if (rst_all) mask <= '0;
      else if (wr & hit_ies) mask <= mask | pwdata[IRQ_SRC_W-1:0]; // [R17]
      else if (wr & hit_iec) mask <= mask & ~pwdata[IRQ_SRC_W-1:0]; // [R18]
   end

   // enable state; disable waits for the shifter, a fault stops at once
   always_ff @(posedge ref_clk) begin
      if (rst_all) begin
         enabled <= 1'b0;
         dis_pending <= 1'b0;
      end else if (fault_cond) begin
         enabled <= 1'b0;
         dis_pending <= 1'b0;
      end else if (cmd_dis | dis_pending) begin
         dis_pending <= (state != ST_IDLE);
         enabled <= enabled & (state != ST_IDLE);
      end else if (cmd_en) begin
         enabled <= 1'b1;
      end
   end

   // transmit holding register; a later write overwrites an unsent word
   always_ff @(posedge ref_clk) begin
      if (rst_all) begin
         tx_hold <= 32'h0000_0000;
         tx_full <= 1'b0;
      end else if (wr_tx) begin
         tx_hold <= pwdata; // [R2]
         tx_full <= 1'b1;
      end else begin
         if (start) tx_full <= 1'b0;
         if (wr_ctrl & pwdata[CTRL_FINAL]) tx_hold[TX_FINAL] <= 1'b1;
      end
   end

   // transmit-empty: a write that lands with a move leaves new data pending
   always_ff @(posedge ref_clk) begin
      if (rst_all) tx_empty <= 1'b0;
      else if (wr_tx) tx_empty <= 1'b0; // [R8]
      else if (~enabled & ~cmd_en | en_drop) tx_empty <= 1'b0; // [R8]
      else if (start | cmd_en) tx_empty <= 1'b1; // [R8]
   end

   // transmitter idle flag
   wire idle_set = enabled & (state == ST_IDLE) & ~tx_full & ~start;
   always_ff @(posedge ref_clk) begin
      if (rst_all) idle_flag <= 1'b0;
      else if (wr_tx) idle_flag <= 1'b0; // [R15]
      else if (idle_set) idle_flag <= 1'b1; // [R15]
   end

   // receive holding and its flags; hardware sets win over clears
   always_ff @(posedge ref_clk) begin
      if (rst_all) begin
         rx_data <= 16'h0000;
         rx_code <= 4'h0;
         rx_full <= 1'b0;
         overrun <= 1'b0;
      end else begin
         if (rx_load) begin
            rx_data <= rx_sh; // last bit already taken on the rising tick
            rx_code <= chip_select_lines; // [R1]
         end
         if (rx_load) rx_full <= 1'b1; // [R7]
         else if (rd_rx) rx_full <= 1'b0; // [R7]
         if (rx_load & rx_full & ~rd_rx) overrun <= 1'b1; // [R10]
         else if (rd_stat) overrun <= 1'b0; // [R10]
      end
   end

   // event flags cleared by status read or by dma counter writes
   always_ff @(posedge ref_clk) begin
      if (rst_all) begin
         fault <= STATUS_RESET[ST_FAULT];
         ss_rise <= STATUS_RESET[ST_SS_RISE];
         rx_done <= STATUS_RESET[ST_RX_DONE]; // [R22]
         tx_done <= STATUS_RESET[ST_TX_DONE]; // [R22]
         rx_zero_d <= 1'b1;
         tx_zero_d <= 1'b1;
      end else begin
         rx_zero_d <= rx_zero;
         tx_zero_d <= tx_zero;
         if (fault_cond) fault <= 1'b1; // [R9]
         else if (rd_stat) fault <= 1'b0; // [R9]
         if (ss_edge) ss_rise <= 1'b1; // [R14]
         else if (rd_stat) ss_rise <= 1'b0; // [R14]
         if (rx_zero & ~rx_zero_d) rx_done <= 1'b1; // [R11]
         else if (receive_counter_write) rx_done <= 1'b0; // [R11]
         if (tx_zero & ~tx_zero_d) tx_done <= 1'b1; // [R12]
         else if (transmit_counter_write) tx_done <= 1'b0; // [R12]
      end
   end

   // shifter: mode 0 timing, msb first, half period of scbr cycles
   always_ff @(posedge ref_clk) begin
      if (rst_all) begin
         state <= ST_IDLE;
         tx_sh <= 16'h0000;
         rx_sh <= 16'h0000;
         nbits <= MIN_BITS;
         bit_cnt <= 5'h00;
         div_cnt <= 8'h00;
         half_div <= 8'h01;
         gap_cnt <= 13'h0000;
         spck <= 1'b0;
         mosi <= 1'b0;
         cur_code <= CS_NONE;
         cur_idx <= 2'h0;
         cs_active <= 1'b0;
         sh_final <= 1'b0;
      end else begin
         unique case (state)
            ST_IDLE: begin
               if (start) begin
                  tx_sh <= tx_hold[15:0] << (MAX_BITS - word_bits);
                  mosi <= tx_hold[word_bits - 5'h01];
                  rx_sh <= 16'h0000;
                  nbits <= word_bits;
                  bit_cnt <= 5'h00;
                  div_cnt <= 8'h00;
                  cur_code <= word_code; // [R3] [R21]
                  cur_idx <= word_idx;
                  cs_active <= 1'b1;
                  sh_final <= mode_reg[MODE_VAR_SELECT] & tx_hold[TX_FINAL];
                  state <= ST_SHIFT;
               end
               half_div <= half_now;
            end
            ST_SHIFT: begin
               if (div_tick) begin
                  div_cnt <= 8'h00;
                  spck <= ~spck;
                  if (!spck) begin
                     rx_sh <= {rx_sh[14:0], miso_bit};
                  end else begin
                     tx_sh <= {tx_sh[14:0], 1'b0};
                     mosi <= tx_sh[14];
                     bit_cnt <= bit_cnt + 5'h01;
                  end
               end else begin
                  div_cnt <= div_cnt + 8'h01;
               end
               if (last_bit) begin
                  gap_cnt <= 13'(GAP_UNIT * cur_dlybct);
                  state <= ST_GAP;
               end
            end
            ST_GAP: begin
               if (gap_end) begin
                  if (release_cs) cs_active <= 1'b0; // [R6] [R21]
                  sh_final <= 1'b0;
                  state <= ST_IDLE;
               end else begin
                  gap_cnt <= gap_cnt - 13'h0001;
               end
            end
            default: state <= ST_IDLE;
         endcase
         if (fault_cond) cs_active <= 1'b0;
      end
   end

   // checks on the logic above
   AST_RX_FULL_SET: assert property (@(posedge ref_clk) disable iff (rst_all)
      rx_load |=> rx_full ##1 (rx_full || $past(rd_rx)))
      else $error("receive full not raised on load"); // [R7]
   AST_RX_FULL_CLR: assert property (@(posedge ref_clk) disable iff (rst_all)
      rd_rx && !rx_load |=> !rx_full)
      else $error("receive full not cleared by read"); // [R7]
   AST_OVERRUN: assert property (@(posedge ref_clk) disable iff (rst_all)
      rx_load && rx_full && !rd_rx |=> overrun && status_word[ST_OVERRUN])
      else $error("overrun missed"); // [R10]
   AST_TX_EMPTY_WR: assert property (@(posedge ref_clk) disable iff (rst_all)
      wr_tx |=> !tx_empty && !idle_flag && tx_full)
      else $error("transmit write did not clear empty flags"); // [R8]
   AST_TX_EMPTY_DIS: assert property (@(posedge ref_clk) disable iff (rst_all)
      !enabled && !$past(cmd_en) |-> !tx_empty)
      else $error("transmit empty high while disabled"); // [R8]
   AST_LINES_DIRECT: assert property (@(posedge ref_clk) disable iff (rst_all)
      cs_active && dec |-> chip_select_lines == cur_code)
      else $error("decoded select lines differ from code"); // [R5]
   AST_LINES_PRIO: assert property (@(posedge ref_clk) disable iff (rst_all)
      cs_active && !dec && cur_code[1:0] == 2'b01 |->
      chip_select_lines == 4'hd)
      else $error("priority select lines wrong"); // [R4]
   AST_FINAL_RELEASE: assert property (@(posedge ref_clk)
      disable iff (rst_all)
      gap_end && sh_final |=> chip_select_lines == CS_NONE)
      else $error("final transfer did not release select"); // [R6]
   AST_MASK_SET: assert property (@(posedge ref_clk) disable iff (rst_all)
      wr && hit_ies |=> (mask & $past(pwdata[IRQ_SRC_W-1:0])) ==
      $past(pwdata[IRQ_SRC_W-1:0]))
      else $error("enable write did not set mask"); // [R17]
   AST_MASK_CLR: assert property (@(posedge ref_clk) disable iff (rst_all)
      wr && hit_iec |=> (mask & $past(pwdata[IRQ_SRC_W-1:0])) == '0)
      else $error("disable write did not clear mask"); // [R18]
   AST_SS_RISE_IRQ: assert property (@(posedge ref_clk) disable iff (rst_all)
      ss_edge && mask[ST_SS_RISE] |=> irq)
      else $error("slave select rise did not raise interrupt"); // [R14] [R23]
   AST_RX_CODE_SLAVE: assert property (@(posedge ref_clk)
      disable iff (rst_all)
      setup && hit_rx && !master |=> prdata[19:16] == 4'h0)
      else $error("receive code nonzero outside master"); // [R1]
   AST_IDLE_GAP: assert property (@(posedge ref_clk) disable iff (rst_all)
      state == ST_GAP && !$past(wr_tx) && $past(state) == ST_SHIFT |->
      !idle_flag)
      else $error("idle flag set during transfer delay"); // [R15]
endmodule : spi_status_irq_regs

// ### spi_peer_model.sv
/* serial peer model: answers each frame with a fixed byte and captures
   mosi; assumes mode 0 framing with spck timed from ref_clk. */
`timescale 1ns/1ps
module spi_peer_model (
   input wire logic ref_clk,
   input wire logic spck,
   input wire logic mosi,
   input wire logic [3:0] chip_select_lines,
   input wire logic fault,
   output logic miso,
   output logic slave_select_input,
   output logic [7:0] cap
);
   logic [7:0] sh = 8'ha5;
   logic spck_d = 0, sel_d = 0, last = 0;
   wire sel = chip_select_lines != 4'hf;
   // released miso shows the inverse of its last bit, never a stale copy
   assign miso = sel ? sh[7] : ~last;
   assign slave_select_input = ~fault; // pulled up unless commanded low
   // reload at frame start, shift on falling spck, capture on rising
   always @(posedge ref_clk) begin
      spck_d <= spck;
      sel_d <= sel;
      if (sel) last <= sh[7];
      if (sel && !sel_d) sh <= 8'ha5;
      else if (spck_d && !spck) sh <= {sh[6:0], 1'b0};
      if (!spck_d && spck) cap <= {cap[6:0], mosi};
   end
endmodule : spi_peer_model

// ### spi_status_irq_regs_bench.sv
/* self-checking bench: apb master tasks, read-data monitor, serial peer.
   assumes the package and the peer model are compiled first. */
`timescale 1ns/1ps
module spi_status_irq_regs_bench;
   import spi_regs_pkg::*;
   logic ref_clk = 0, reset = 1, psel = 0, penable = 0, pwrite = 0;
   logic [7:0] paddr = 8'h00, cap;
   logic [31:0] pwdata = 32'h0, prdata, mq, seed = 32'ha4c95ef7;
   logic pready, pslverr, spck, mosi, miso, ssi, irq;
   logic fault = 0, rcw = 0, tcw = 0;
   logic [3:0] lines;
   logic [15:0] rc = 0, rnc = 0, tc = 0, tnc = 0, a, b, c, d;
   logic [31:0] exp_q[$], msk_q[$];
   logic [3:0] cd[5] = '{4'h6, 4'h9, 4'h3, 4'h7, 4'h5};
   logic [3:0] le[5] = '{4'he, 4'hd, 4'hb, 4'h7, 4'h5};
   int fail_count = 0, total_checks = 0, n;
   always #2.5 ref_clk = ~ref_clk;
   spi_status_irq_regs #(.CNT_W(16)) spi_status_irq_regs_inst (
      .ref_clk(ref_clk), .reset(reset), .paddr(paddr), .psel(psel),
      .penable(penable), .pwrite(pwrite), .pwdata(pwdata),
      .prdata(prdata), .pready(pready), .pslverr(pslverr), .spck(spck),
      .mosi(mosi), .miso(miso), .slave_select_input(ssi),
      .chip_select_lines(lines), .receive_counter(rc),
      .receive_next_counter(rnc), .transmit_counter(tc),
      .transmit_next_counter(tnc), .receive_counter_write(rcw),
      .transmit_counter_write(tcw), .irq(irq));
   spi_peer_model spi_peer_model_inst (.ref_clk(ref_clk), .spck(spck),
      .mosi(mosi), .chip_select_lines(lines), .fault(fault), .miso(miso),
      .slave_select_input(ssi), .cap(cap));
   function automatic logic [31:0] xs(input logic [31:0] s);
      logic [31:0] x;
      x = s ^ (s << 13);
      x = x ^ (x >> 17);
      return x ^ (x << 5);
   endfunction : xs
   task automatic check(input string nm, input logic [31:0] seen,
                        input logic [31:0] ex);
      total_checks++;
      if (seen !== ex) begin
         fail_count++;
         $display("mismatch %s expected %h seen %h", nm, ex, seen);
      end
   endtask : check
   task automatic complete_run();
      if (fail_count == 0 && total_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask : complete_run
   // one transfer: setup, then access held until pready is sampled high
   task automatic apb(input logic [7:0] ad, input logic w,
                      input logic [31:0] dt, input logic [31:0] m);
      @(posedge ref_clk);
      paddr <= ad;
      pwrite <= w;
      pwdata <= w ? dt : 32'h0;
      psel <= 1'b1;
      penable <= 1'b0;
      if (!w) begin
         exp_q.push_back(dt);
         msk_q.push_back(m);
      end
      @(posedge ref_clk);
      penable <= 1'b1;
      do begin @(posedge ref_clk); end while (pready !== 1'b1);
      psel <= 1'b0;
      penable <= 1'b0;
   endtask : apb
   task automatic wait_lines(input logic rel);
      n = 0;
      do begin @(negedge ref_clk); n++; end
      while ((lines === 4'hf) !== rel && n < 3000);
      if (n >= 3000) check("select wait", 32'h0, 32'h1);
   endtask : wait_lines
   task automatic pulse();
      @(posedge ref_clk);
      rcw <= 1'b1;
      tcw <= 1'b1;
      @(posedge ref_clk);
      rcw <= 1'b0;
      tcw <= 1'b0;
   endtask : pulse
   // read data is compared against the oldest note at the access edge
   always @(posedge ref_clk) begin
      if (psel && penable && pready === 1'b1 && !pwrite && exp_q.size()) begin
         check("pslverr", {31'h0, pslverr}, {31'h0, paddr == 8'h20});
         mq = msk_q.pop_front();
         check("prdata", prdata & mq, exp_q.pop_front() & mq);
      end
   end
   // a hang counts as a mismatch and ends through the same closing task
   initial begin
      repeat (30000) @(posedge ref_clk);
      fail_count++;
      complete_run();
   end
   initial begin
      repeat (4) @(posedge ref_clk);
      reset <= 1'b0;
      apb(OFF_STATUS_FLAGS, 0, 32'hf0, '1);
      apb(8'h20, 0, 32'h0, '1);
      apb(OFF_IRQ_ENABLE_SET, 1, 32'h3ff, 0);
      apb(OFF_IRQ_ENABLE_VIEW, 0, 32'h3ff, '1);
      @(negedge ref_clk) check("irq", {31'h0, irq}, 32'h1);
      apb(OFF_IRQ_ENABLE_CLEAR, 1, 32'h0f0, 0);
      apb(OFF_IRQ_ENABLE_VIEW, 0, 32'h30f, '1);
      @(negedge ref_clk) check("irq", {31'h0, irq}, 32'h0);
      apb(OFF_IRQ_ENABLE_CLEAR, 1, 32'h3ff, 0);
      // random counter mixes, zero half the time each
      repeat (8) begin
         seed = xs(seed);
         a = seed[0] ? 16'h0 : seed[31:16];
         b = seed[1] ? 16'h0 : {8'h0, seed[15:8]};
         c = seed[2] ? 16'h0 : {8'h0, seed[23:16]};
         d = seed[3] ? 16'h0 : {12'h0, seed[7:4]};
         @(posedge ref_clk);
         {rc, rnc, tc, tnc} <= {a, b, c, d};
         apb(OFF_STATUS_FLAGS, 0, {24'h0, c == 0 && d == 0,
             a == 0 && b == 0, 6'h0}, 32'hc0);
      end
      @(posedge ref_clk);
      {rc, tc} <= {16'h5, 16'h5};
      pulse();
      apb(OFF_STATUS_FLAGS, 0, 32'h0, 32'h30);
      {rc, tc} <= 32'h0;
      apb(OFF_STATUS_FLAGS, 0, 32'h30, 32'h30);
      pulse();
      apb(OFF_STATUS_FLAGS, 0, 32'h0, 32'h30);
      apb(OFF_CTRL, 1, 32'h1, 0);
      apb(OFF_STATUS_FLAGS, 0, 32'h10002, 32'h10002);
      for (int k = 0; k < 4; k++) apb(8'h30 + 8'(4 * k), 1, 32'h0808, 0);
      // per-word codes, held selects closed by the final-transfer flag
      for (int i = 0; i < 5; i++) begin
         seed = xs(seed);
         apb(OFF_MODE, 1, i == 4 ? 32'h7 : 32'h3, 0);
         apb(OFF_TX_HOLDING, 1, {7'h0, 1'b1, 4'h0, cd[i], seed[15:0]}, 0);
         wait_lines(1'b0);
         check("select", {28'h0, lines}, {28'h0, le[i]});
         wait_lines(1'b1);
         repeat (2) @(negedge ref_clk);
         check("mosi", {24'h0, cap}, {24'h0, seed[7:0]});
         apb(OFF_STATUS_FLAGS, 0, i == 1 ? 32'h20b : 32'h203,
             32'h20b);
         if (i > 0) apb(OFF_RX_HOLDING, 0, {12'h0, le[i], 16'h00a5}, '1);
      end
      apb(OFF_MODE, 1, 32'h000b0001, 0);
      apb(OFF_TX_HOLDING, 1, 32'h00000055, 0);
      wait_lines(1'b0);
      check("select", {28'h0, lines}, 32'hb);
      repeat (400) @(negedge ref_clk);
      check("select", {28'h0, lines}, 32'hb);
      apb(OFF_IRQ_ENABLE_SET, 1, 32'h100, 0);
      @(posedge ref_clk);
      fault <= 1'b1;
      repeat (8) @(posedge ref_clk);
      fault <= 1'b0;
      repeat (8) @(posedge ref_clk);
      @(negedge ref_clk) check("irq", {31'h0, irq}, 32'h1);
      apb(OFF_STATUS_FLAGS, 0, 32'h104, 32'h10106);
      apb(OFF_STATUS_FLAGS, 0, 32'h0, 32'h104);
      @(negedge ref_clk) check("irq", {31'h0, irq}, 32'h0);
      apb(OFF_MODE, 1, 32'h0, 0);
      apb(OFF_RX_HOLDING, 0, 32'h000000a5, '1);
      apb(OFF_CTRL, 1, 32'h80, 0);
      apb(OFF_STATUS_FLAGS, 0, 32'h30, 32'h1033f);
      complete_run();
   end
endmodule : spi_status_irq_regs_bench
